// file: core/dtg_pkg.sv
/*
  Package for the command timing guard: command codes, request and
  answer structs, and each fixed spacing limit as a time, a cycle count or both.
  Assumes the guard and the controller share one 100 MHz clock.
*/
package dtg_pkg;

  localparam int CLK_PERIOD_PS = 10000;

  // Least times round up to whole cycles, never below one
  function automatic int ps_to_cyc(input int t_ps);
    int c;
    c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int DLLK_NCK = 512;
  localparam int RTP_NCK = 4;
  localparam int RTP_PS = 7500;
  localparam int WTR_NCK = 4;
  localparam int WTR_PS = 7500;
  localparam int MRD_NCK = 4;
  localparam int MOD_NCK = 12;
  localparam int MOD_PS = 15000;
  localparam int CCD_NCK = 4;
  localparam int RRD_NCK = 4;
  localparam int RRD_PS = 6000;
  localparam int FAW_PS = 35000;
  localparam int ZQINIT_NCK = 512;
  localparam int ZQINIT_PS = 640000;
  localparam int ZQOPER_NCK = 256;
  localparam int ZQOPER_PS = 320000;
  localparam int ZQCS_NCK = 64;
  localparam int ZQCS_PS = 80000;
  localparam int XPR_NCK = 5;
  localparam int XPR_EXTRA_PS = 10000;
  localparam int CKSRE_NCK = 5;
  localparam int CKSRE_PS = 10000;
  localparam int XP_NCK = 3;
  localparam int XP_PS = 6000;
  localparam int XPDLL_NCK = 10;
  localparam int XPDLL_PS = 24000;
  localparam int CKE_NCK = 3;
  localparam int CKE_PS = 5000;
  localparam int PD_MAX_REFI = 9;
  localparam int CPDED_NCK = 2;
  localparam int RDPDEN_ADD = 4 + 1;
  localparam int ODTH4_NCK = 4;
  localparam int ODTH8_NCK = 6;
  localparam int WLMRD_NCK = 40;
  localparam int WLDQSEN_NCK = 25;
  localparam int WR_START_BL8 = 4;
  localparam int WR_START_BC4 = 2;

  localparam int RTP_CYC = max2(RTP_NCK, ps_to_cyc(RTP_PS));
  localparam int WTR_CYC = max2(WTR_NCK, ps_to_cyc(WTR_PS));
  localparam int MOD_CYC = max2(MOD_NCK, ps_to_cyc(MOD_PS));
  localparam int RRD_CYC = max2(RRD_NCK, ps_to_cyc(RRD_PS));
  localparam int FAW_CYC = ps_to_cyc(FAW_PS);
  localparam int ZQINIT_CYC = max2(ZQINIT_NCK, ps_to_cyc(ZQINIT_PS));
  localparam int ZQOPER_CYC = max2(ZQOPER_NCK, ps_to_cyc(ZQOPER_PS));
  localparam int ZQCS_CYC = max2(ZQCS_NCK, ps_to_cyc(ZQCS_PS));
  localparam int CKSRE_CYC = max2(CKSRE_NCK, ps_to_cyc(CKSRE_PS));
  localparam int XP_CYC = max2(XP_NCK, ps_to_cyc(XP_PS));
  localparam int XPDLL_CYC = max2(XPDLL_NCK, ps_to_cyc(XPDLL_PS));
  localparam int CKE_CYC = max2(CKE_NCK, ps_to_cyc(CKE_PS));

  localparam int CW = 10;
  localparam int BANKS = 8;
  localparam int BW = 3;

  typedef enum logic [3:0] {
    DTG_NOP = 4'h0,
    DTG_ACT = 4'h1,
    DTG_RD = 4'h2,
    DTG_RDA = 4'h3,
    DTG_WR = 4'h4,
    DTG_WRA = 4'h5,
    DTG_PRE = 4'h6,
    DTG_MRS = 4'h7,
    DTG_ZQCL = 4'h8,
    DTG_ZQCS = 4'h9,
    DTG_REF = 4'hA,
    DTG_PDE = 4'hB,
    DTG_PDX = 4'hC,
    DTG_SRE = 4'hD,
    DTG_SRX = 4'hE,
    DTG_ODT = 4'hF
  } dtg_cmd_t;

  typedef struct packed {
    logic valid;
    dtg_cmd_t cmd;
    logic [BW-1:0] bank;
    logic bl8;
    logic wlev;
    logic dll_frozen;
  } dtg_req_t;

  typedef struct packed {
    logic ready;
    logic issue;
    dtg_cmd_t cmd;
    logic [BW-1:0] bank;
    logic cke;
    logic odt;
    logic dqs_oe_ok;
    logic dqs_edge_ok;
    logic pd_overdue;
  } dtg_out_t;

  typedef enum logic [1:0] {
    DTG_ST_INIT = 2'b00,
    DTG_ST_RUN = 2'b01,
    DTG_ST_PD = 2'b10,
    DTG_ST_SR = 2'b11
  } dtg_state_t;

endpackage

// file: core/dtg_guard.sv
/*
  Command timing guard: a host-side gate that holds back commands to a
  DDR3L x16 device until every spacing limit listed below has run out.
  Assumes one clock shared with the controller; requests are held
  stable until ready; the clock enable pin is driven from here.
*/
// Behaviour
// - After self refresh exit, DLL commands wait 512 cycles.
// - Read to precharge same bank needs max of 4 cycles, 7.5 ns.
// - Write transaction start to read needs max of 4 cycles, 7.5 ns.
// - Write with auto-precharge busies the bank write recovery plus precharge.
// - Mode register commands stand at least 4 cycles apart.
// - After mode register set, others wait max of 12 cycles, 15 ns.
// - Column commands stand at least 4 cycles apart.
// - Activates to different banks need max of 4 cycles, 6 ns.
// - At most four activates in any rolling 35 ns window.
// - Initial calibration takes max of 512 cycles, 640 ns.
// - Long calibration 256 cycles/320 ns, short 64 cycles/80 ns.
// - After reset exit wait max of 5 cycles, refresh time plus 10 ns.
// - Non-DLL commands after self refresh exit wait the same span.
// - Clock stays valid 5 cycles/10 ns after entry and before exit.
// - Power-down exit to commands waits max of 3 cycles, 6 ns.
// - Frozen-DLL power-down exit to DLL commands waits 10 cycles/24 ns.
// - Power-down lasts at least 3 cycles/5 ns, at most 9 refresh intervals; the guard only raises pd_overdue past that.
// - Two cycles after clock enable low, commands must stay legal.
// - Power-down entry waits read latency plus 4 plus 1 after a read.
// - Termination stays high 4 cycles, or 6 for an 8-beat write.
// - Write leveling: strobe edge after 40 cycles, drivers after 25.
// - Nanosecond minimums round up to whole cycles.
// - Only reads and synchronous termination need a locked DLL.
`timescale 1ns/100ps
`default_nettype none
module dtg_guard
  import dtg_pkg::*;
#(
  parameter int RFC_PS = 260000,
  parameter int WR_NCK = 16,
  parameter int RP_NCK = 14,
  parameter int RL_NCK = 14,
  parameter int WL_NCK = 10,
  parameter int REFI_CYC = 780
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire dtg_req_t req,
  output var dtg_out_t out
);

  localparam int XS_CYC = max2(XPR_NCK, ps_to_cyc(RFC_PS + XPR_EXTRA_PS));
  localparam int DAL_CYC = WR_NCK + RP_NCK;
  localparam int RDPDEN_CYC = RL_NCK + RDPDEN_ADD;
  localparam int WTR_LEAD = WL_NCK + WR_START_BL8 + WTR_CYC;
  localparam int PDMAX = PD_MAX_REFI * REFI_CYC;
  localparam int PW = 16;
  localparam int PD_HOLD = max2(max2(CKSRE_CYC, CKE_CYC), CPDED_NCK);
  localparam logic [CW-1:0] XS_LOAD = CW'(XS_CYC - 1);

  // Every span must fit its down-counter; a wrapped load would let a
  // command through far too early
  if (DAL_CYC >= (1 << CW)) begin : g_dal_chk
    $error("dtg_guard: write recovery span exceeds counter width");
  end
  if (XS_CYC >= (1 << CW)) begin : g_xs_chk
    $error("dtg_guard: exit span exceeds counter width");
  end
  if (WTR_LEAD >= (1 << CW)) begin : g_wtr_chk
    $error("dtg_guard: write to read span exceeds counter width");
  end
  if (RDPDEN_CYC >= (1 << CW)) begin : g_rdpden_chk
    $error("dtg_guard: read to power-down span exceeds counter width");
  end
  if (ZQINIT_CYC >= (1 << CW) || DLLK_NCK >= (1 << CW)) begin : g_pkg_chk
    $error("dtg_guard: calibration or lock span exceeds counter width");
  end
  if (PDMAX >= (1 << PW) || REFI_CYC < 1) begin : g_pd_chk
    $error("dtg_guard: power-down limit outside its counter");
  end
  if (RL_NCK < 1 || WL_NCK < 1 || RP_NCK < 1 || WR_NCK < 1) begin : g_lat_chk
    $error("dtg_guard: latencies must be at least one cycle");
  end
  if (BANKS != (1 << BW)) begin : g_bank_chk
    $error("dtg_guard: bank count does not match bank address width");
  end

  typedef struct packed {
    dtg_state_t st;
    logic [CW-1:0] c_cmd;
    logic [CW-1:0] c_dll;
    logic [CW-1:0] c_mrd;
    logic [CW-1:0] c_ccd;
    logic [CW-1:0] c_rrd;
    logic [CW-1:0] c_wtr;
    logic [CW-1:0] c_pde;
    logic [CW-1:0] c_clk;
    logic [CW-1:0] c_odt;
    logic [CW-1:0] c_wl_oe;
    logic [CW-1:0] c_wl_edge;
    logic [PW-1:0] c_pd;
    logic [BANKS-1:0][CW-1:0] c_bank;
    logic [3:0][CW-1:0] c_faw;
    logic zq_first;
    logic mod_only;
    dtg_out_t o;
  } dtg_s_t;

  dtg_s_t s;
  dtg_s_t next_s;
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] c);
    return (c != '0) ? c - 1'b1 : c;
  endfunction

  function automatic logic [CW-1:0] cw(input int v);
    return v[CW-1:0];
  endfunction

  function automatic logic [CW-1:0] mx(input logic [CW-1:0] c,
                                       input int v);
    return (c > v[CW-1:0]) ? c : v[CW-1:0];
  endfunction

  logic is_col;
  logic is_rd;
  logic needs_dll;
  logic faw_free;
  logic ok;
  int slot;

  always_comb begin
    next_s = s;
    is_rd = (req.cmd == DTG_RD) || (req.cmd == DTG_RDA);
    is_col = is_rd || (req.cmd == DTG_WR) || (req.cmd == DTG_WRA);
    needs_dll = is_rd || (req.cmd == DTG_ODT);
    faw_free = 1'b0;
    slot = 0;
    for (int i = 3; i >= 0; i--) begin
      if (s.c_faw[i] == '0) begin
        faw_free = 1'b1;
        slot = i;
      end
    end
    next_s.c_cmd = dec(s.c_cmd);
    next_s.c_dll = dec(s.c_dll);
    next_s.c_mrd = dec(s.c_mrd);
    next_s.c_ccd = dec(s.c_ccd);
    next_s.c_rrd = dec(s.c_rrd);
    next_s.c_wtr = dec(s.c_wtr);
    next_s.c_pde = dec(s.c_pde);
    next_s.c_clk = dec(s.c_clk);
    next_s.c_odt = dec(s.c_odt);
    next_s.c_wl_oe = dec(s.c_wl_oe);
    next_s.c_wl_edge = dec(s.c_wl_edge);
    for (int b = 0; b < BANKS; b++) begin
      next_s.c_bank[b] = dec(s.c_bank[b]);
    end
    for (int f = 0; f < 4; f++) begin
      next_s.c_faw[f] = dec(s.c_faw[f]);
    end
    if (s.st == DTG_ST_PD && s.c_pd != '0) begin
      next_s.c_pd = s.c_pd - 1'b1;
    end
    ok = (s.c_cmd == '0) && !(needs_dll && s.c_dll != '0);
    case (req.cmd)
      DTG_NOP: ok = 1'b0;
      DTG_ACT: begin
        ok = ok && s.st == DTG_ST_RUN;
        ok = ok && s.c_rrd == '0;
        ok = ok && faw_free;
        ok = ok && s.c_bank[req.bank] == '0;
      end
      DTG_RD, DTG_RDA: begin
        ok = ok && s.st == DTG_ST_RUN;
        ok = ok && s.c_ccd == '0;
        ok = ok && s.c_wtr == '0;
      end
      DTG_WR, DTG_WRA: begin
        ok = ok && s.st == DTG_ST_RUN;
        ok = ok && s.c_ccd == '0;
      end
      DTG_PRE: begin
        ok = ok && s.st == DTG_ST_RUN;
        ok = ok && s.c_bank[req.bank] == '0;
      end
      // Mode sets may follow each other inside the update delay; any
      // other load of the command counter still holds them back
      DTG_MRS: begin
        ok = s.c_mrd == '0;
        ok = ok && (s.st == DTG_ST_RUN || s.st == DTG_ST_INIT);
        ok = ok && (s.c_cmd == '0 || s.mod_only);
      end
      DTG_PDE, DTG_SRE: begin
        ok = ok && s.st == DTG_ST_RUN;
        ok = ok && s.c_pde == '0;
      end
      DTG_PDX: begin
        ok = s.st == DTG_ST_PD;
        ok = ok && s.c_clk == '0;
      end
      DTG_SRX: begin
        ok = s.st == DTG_ST_SR;
        ok = ok && s.c_clk == '0;
      end
      DTG_ZQCL: begin
        ok = ok && (s.st == DTG_ST_RUN || s.st == DTG_ST_INIT);
      end
      default: ok = ok && s.st == DTG_ST_RUN;
    endcase
    if (s.st == DTG_ST_INIT && req.cmd != DTG_ZQCL && req.cmd != DTG_MRS) begin
      ok = ok && s.c_cmd == '0 && !s.zq_first;
    end
    ok = ok && req.valid && rst_n;
    next_s.o.ready = ok;
    next_s.o.issue = ok;
    next_s.o.cmd = ok ? req.cmd : DTG_NOP;
    next_s.o.bank = ok ? req.bank : s.o.bank;
    next_s.o.pd_overdue = (s.st == DTG_ST_PD) && (s.c_pd == '0);
    if (ok) begin
      case (req.cmd)
        DTG_ACT: begin
          next_s.c_rrd = cw(RRD_CYC - 1);
          next_s.c_faw[slot] = cw(FAW_CYC - 1);
        end
        DTG_RD, DTG_RDA: begin
          next_s.c_ccd = cw(CCD_NCK - 1);
          next_s.c_bank[req.bank] = mx(next_s.c_bank[req.bank],
                                       RTP_CYC - 1);
          next_s.c_pde = mx(next_s.c_pde, RDPDEN_CYC - 1);
        end
        DTG_WR, DTG_WRA: begin
          next_s.c_ccd = cw(CCD_NCK - 1);
          next_s.c_wtr = cw(WL_NCK + (req.bl8 ? WR_START_BL8 : WR_START_BC4)
                            + WTR_CYC - 1);
          if (req.cmd == DTG_WRA) begin
            next_s.c_bank[req.bank] = cw(DAL_CYC - 1);
          end
          next_s.c_odt = cw((req.bl8 ? ODTH8_NCK : ODTH4_NCK) - 1);
          next_s.o.odt = 1'b1;
        end
        DTG_MRS: begin
          next_s.c_mrd = cw(MRD_NCK - 1);
          next_s.c_cmd = cw(MOD_CYC - 1);
          next_s.mod_only = 1'b1;
          next_s.c_pde = mx(next_s.c_pde, MOD_CYC - 1);
          if (req.wlev) begin
            next_s.c_wl_oe = cw(WLDQSEN_NCK);
            next_s.c_wl_edge = cw(WLMRD_NCK);
          end
        end
        DTG_ZQCL: begin
          next_s.c_cmd = cw((s.zq_first ? ZQINIT_CYC : ZQOPER_CYC) - 1);
          next_s.zq_first = 1'b0;
          next_s.mod_only = 1'b0;
          next_s.st = DTG_ST_RUN;
        end
        DTG_ZQCS: begin
          next_s.c_cmd = cw(ZQCS_CYC - 1);
          next_s.mod_only = 1'b0;
        end
        DTG_ODT: begin
          next_s.c_odt = cw(ODTH4_NCK - 1);
          next_s.o.odt = 1'b1;
        end
        DTG_PDE, DTG_SRE: begin
          next_s.st = (req.cmd == DTG_PDE) ? DTG_ST_PD : DTG_ST_SR;
          next_s.o.cke = 1'b0;
          // Self refresh keeps the clock enable low one cycle longer
          next_s.c_clk = cw(PD_HOLD - 1 + (req.cmd == DTG_SRE ? 1 : 0));
          next_s.c_pd = PDMAX[PW-1:0];
        end
        DTG_PDX: begin
          next_s.st = DTG_ST_RUN;
          next_s.o.cke = 1'b1;
          next_s.c_cmd = cw(XP_CYC - 1);
          next_s.mod_only = 1'b0;
          if (req.dll_frozen) begin
            next_s.c_dll = cw(XPDLL_CYC - 1);
          end
        end
        DTG_SRX: begin
          next_s.st = DTG_ST_RUN;
          next_s.o.cke = 1'b1;
          next_s.c_cmd = cw(XS_CYC - 1);
          next_s.mod_only = 1'b0;
          next_s.c_dll = cw(DLLK_NCK - 1);
        end
        default: begin
        end
      endcase
    end
    if (s.c_odt == '0 && !(ok && (is_col || req.cmd == DTG_ODT))) begin
      if (!(ok && (req.cmd == DTG_WR || req.cmd == DTG_WRA))) begin
        next_s.o.odt = 1'b0;
      end
    end
    next_s.o.dqs_oe_ok = (s.c_wl_oe == '0);
    next_s.o.dqs_edge_ok = (s.c_wl_edge == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= DTG_ST_INIT;
      s.c_cmd <= XS_LOAD;
      s.zq_first <= 1'b1;
      s.o.cke <= 1'b1;
      s.o.dqs_oe_ok <= 1'b1;
      s.o.dqs_edge_ok <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign out = s.o;

endmodule
`default_nettype wire

// file: verif/dtg_guard_sva.sv
/* Port checker for the command timing guard.
   Assumes the guard's ports as the package declares them. */
`timescale 1ns/100ps
`default_nettype none
module dtg_guard_chk
  import dtg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire dtg_req_t req,
  input wire dtg_out_t out
);
  logic [3:0] mod_cnt;
  logic i_mrs;
  logic i_act;
  logic i_col;
  assign i_mrs = out.issue && out.cmd == DTG_MRS;
  assign i_act = out.issue && out.cmd == DTG_ACT;
  assign i_col = out.issue && out.cmd inside {DTG_RD, DTG_RDA, DTG_WR,
    DTG_WRA};
  // Reloads on every mode set, since the guard lets them run inside it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      mod_cnt <= 4'h0;
    else if (i_mrs)
      mod_cnt <= 4'(MOD_CYC - 1);
    else if (mod_cnt != 4'h0)
      mod_cnt <= mod_cnt - 4'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_cmd_echo: assert property (out.issue |->
    $past(req.valid) && out.cmd == $past(req.cmd)) else $error("echo");
  a_mrs_space: assert property (i_mrs |=> !i_mrs [*3])
    else $error("mode sets close");
  a_mod_wait: assert property (out.issue && !i_mrs |->
    mod_cnt == 4'h0) else $error("update delay");
  a_col_space: assert property (i_col |=> !i_col [*3])
    else $error("column close");
  a_act_space: assert property (i_act |=> !i_act [*3])
    else $error("activate close");
  a_odt_high: assert property ($rose(out.odt) |-> out.odt [*4])
    else $error("odt short");
  a_cke_width: assert property ($fell(out.cke) |-> !out.cke [*3])
    else $error("cke short");
  a_pdx_quiet: assert property (out.issue && out.cmd == DTG_PDX
    |=> !out.issue [*2]) else $error("exit early");
  a_wlev_edge: assert property (i_mrs && $past(req.wlev)
    |=> !out.dqs_edge_ok [*8]) else $error("strobe early");
  c_mrs: cover property (i_mrs);
  c_act: cover property (i_act);
  c_pd: cover property ($fell(out.cke));
  c_mrs_pair: cover property (i_mrs ##4 i_mrs);
endmodule
bind dtg_guard dtg_guard_chk i_chk (.clk(clk), .arst_n(arst_n),
  .req(req), .out(out));
`default_nettype wire

// file: verif/dtg_dev_model.sv
/* Behavioural memory device watching the guard's command outputs.
   Assumes one command a cycle, marked by issue. */
`timescale 1ns/100ps
`default_nettype none
module dtg_dev_model
  import dtg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire dtg_out_t bus,
  output logic dev_err
);
  int cke_low;
  int since_srx;
  logic dll_cmd;
  assign dll_cmd = bus.cmd inside {DTG_RD, DTG_RDA, DTG_ODT};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_err <= 1'b0;
      cke_low <= 0;
      since_srx <= DLLK_NCK;
    end else begin
      cke_low <= bus.cke ? 0 : cke_low + 1;
      if (bus.issue && bus.cmd == DTG_SRX)
        since_srx <= 1;
      else if (since_srx < DLLK_NCK)
        since_srx <= since_srx + 1;
      // Inputs are dead once the pass disable delay has run
      if (bus.issue && cke_low >= CPDED_NCK &&
          !(bus.cmd inside {DTG_PDX, DTG_SRX}))
        dev_err <= 1'b1;
      if (bus.issue && dll_cmd && since_srx < DLLK_NCK)
        dev_err <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_dtg_guard.sv
/* Self-checking bench for the command timing guard and device model.
   Assumes a 100 MHz clock and a shortened refresh interval. */
`timescale 1ns/100ps
`default_nettype none
module tb_dtg_guard
  import dtg_pkg::*;
;
  localparam int REFI = 4;
  localparam int WL = 10;
  localparam int RL = 14;
  localparam int WRC = 16;
  localparam int RPC = 14;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  dtg_req_t req = '0;
  dtg_out_t out;
  logic dev_err;
  logic [2:0] b;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int last_iss = 0;
  dtg_cmd_t exp_cmd[$];
  int exp_gap[$];
  logic [2:0] exp_bank[$];
  initial forever #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  dtg_guard #(.RFC_PS(10000), .WR_NCK(WRC), .RP_NCK(RPC), .RL_NCK(RL),
    .WL_NCK(WL), .REFI_CYC(REFI)) i_dut (.clk(clk), .arst_n(arst_n),
    .req(req), .out(out));
  dtg_dev_model i_dev (.clk(clk), .arst_n(arst_n), .bus(out),
    .dev_err(dev_err));
  task automatic chk(input string w, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic chk_gap(input int mn, input int g);
    comparisons++;
    if (g < mn) begin
      miscompares++;
      $display("[ERR] gap expected >=%0d seen %0d", mn, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Holds the request until ready; one idle cycle between requests
  task automatic send(input dtg_cmd_t c, input int gap,
      input logic x = 1'b0);
    int n;
    @(negedge clk);
    exp_cmd.push_back(c);
    exp_gap.push_back(gap);
    exp_bank.push_back(b);
    req = '{1'b1, c, b, x, x, x};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (out.ready !== 1'b1 && n < 4000);
    req.valid = 1'b0;
    if (n >= 4000)
      chk("ready", 32'h1, 32'h0);
  endtask
  always @(negedge clk) begin
    if (out.issue === 1'b1) begin
      if (exp_cmd.size() == 0)
        chk("extra issue", 32'h0, 32'h1);
      else begin
        chk("cmd", 32'(exp_cmd.pop_front()), 32'(out.cmd));
        chk_gap(exp_gap.pop_front(), cyc - last_iss);
        chk("bank", 32'(exp_bank.pop_front()), 32'(out.bank));
      end
      last_iss = cyc;
    end
  end
  initial begin
    void'($urandom(32'h678d));
    b = 3'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    last_iss = cyc;
    send(DTG_ZQCL, XPR_NCK);
    send(DTG_MRS, ZQINIT_CYC);
    send(DTG_MRS, MRD_NCK);
    $display("init done");
    b = 3'($urandom % 8);
    send(DTG_ACT, MOD_CYC);
    for (int i = 0; i < 4; i++) begin
      b = b + 3'h1;
      send(DTG_ACT, RRD_CYC);
    end
    send(DTG_RD, 1);
    send(DTG_RD, CCD_NCK);
    send(DTG_PRE, RTP_CYC);
    send(DTG_WR, 1, 1'b1);
    send(DTG_RD, WL + WR_START_BL8 + WTR_CYC);
    send(DTG_WRA, CCD_NCK, 1'b1);
    send(DTG_ACT, WRC + RPC);
    $display("bank spacing done");
    send(DTG_MRS, 1, 1'b1);
    @(negedge clk);
    chk("oe_ok", 32'h0, 32'(out.dqs_oe_ok));
    repeat (30) @(negedge clk);
    chk("oe_ok", 32'h1, 32'(out.dqs_oe_ok));
    chk("edge_ok", 32'h0, 32'(out.dqs_edge_ok));
    repeat (15) @(negedge clk);
    chk("edge_ok", 32'h1, 32'(out.dqs_edge_ok));
    send(DTG_ODT, MOD_CYC);
    repeat (2) @(negedge clk);
    chk("odt", 32'h1, 32'(out.odt));
    repeat (2) @(negedge clk);
    chk("odt", 32'h0, 32'(out.odt));
    send(DTG_ZQCS, 1);
    send(DTG_ZQCL, ZQCS_CYC);
    send(DTG_REF, ZQOPER_CYC);
    $display("leveling and calibration done");
    b = 3'($urandom % 8);
    send(DTG_RD, 1);
    send(DTG_PDE, RL + RDPDEN_ADD);
    repeat (9 * REFI + 4) @(negedge clk);
    chk("cke", 32'h0, 32'(out.cke));
    chk("overdue", 32'h1, 32'(out.pd_overdue));
    send(DTG_PDX, CKE_CYC);
    send(DTG_ACT, XP_CYC);
    send(DTG_PDE, 1);
    send(DTG_PDX, CKE_CYC, 1'b1);
    send(DTG_RD, XPDLL_CYC);
    chk("overdue", 32'h0, 32'(out.pd_overdue));
    $display("power-down done");
    send(DTG_SRE, 1);
    send(DTG_SRX, CKSRE_CYC);
    send(DTG_REF, XPR_NCK);
    send(DTG_RD, DLLK_NCK - XPR_NCK);
    $display("self refresh done");
    repeat (20) @(negedge clk);
    chk("dev_err", 32'h0, 32'(dev_err));
    chk("pending", 32'h0, 32'(exp_cmd.size()));
    chk("faw cycles", 32'h4, 32'(FAW_CYC));
    end_of_test();
  end
  initial begin
    #300us;
    chk("finish", 32'h1, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
